// ===== rtl/asc_pkg.sv
package asc_pkg;
  localparam int RESULT_BITS = 16;
  localparam logic [15:0] CODE_MIDPOINT = 16'h8000;
  localparam logic [15:0] CODE_MAX = 16'hffff;
  localparam logic [15:0] CODE_MIN = 16'h0000;
  localparam int CONV_TIME_US = 16600;
  localparam int CONV_MAX_US = 23000;
  localparam int CLK_MHZ = 100;
  localparam int CONV_CYCLES = CONV_TIME_US * CLK_MHZ;
  localparam int CONV_MAX_CYCLES = CONV_MAX_US * CLK_MHZ;
  localparam int SCK_HALF_CYCLES = 7;
  localparam logic [15:0] SAMPLE_RESET = 16'h8000;
  typedef enum logic [1:0] {ASC_CONVERT, ASC_SLEEP, ASC_OUTPUT} asc_state_t;
endpackage

// ===== rtl/asc_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface asc_link_if;
  logic sck;
  logic cs_n;
  logic sdo;
  modport dev (input sck, input cs_n, output sdo);
  modport host (output sck, output cs_n, input sdo);
endinterface
`default_nettype wire

// ===== rtl/asc_device.sv
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Three-wire: sleep automatically after conversion
// - Idle-low host times result, sixteen clocks
// - Idle-low: sixteenth falling edge starts conversion
// - Chip-select rise in output aborts, converts
// - Clock low, select low shows sign bit
// - Select high, clock low: drop rest, convert
// - Extra clocks during conversion change nothing
// - Two-wire: select tied low, no sleep need
// - Two-wire: no abort of transfer
// - Two-wire idle-high: sleep, data output falls
// - Two-wire idle-high: seventeenth pulse starts conversion
// - Two-wire idle-low: skip sleep, show sign
// - Two-wire idle-low: sixteenth falling edge converts
// - Two-wire host checks status, forces conversion
// - Sign bit first, advance per falling edge
// - Clock high, select low: busy high, done low
// - Fixed conversion time, under maximum
// - Offset binary result, clamped at extremes; the code loads sample_code unchanged and does no clamping
module asc_device #(
  parameter int CONV_CYCLES = asc_pkg::CONV_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  asc_link_if.dev link,
  input wire logic [15:0] sample_code,
  output logic conv_busy,
  output logic [15:0] last_result
);
  if (CONV_CYCLES < 1 || CONV_CYCLES > asc_pkg::CONV_MAX_CYCLES) begin : g_bad_conv
    $error("CONV_CYCLES out of range");
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic sck_s1_r, sck_s2_r, sck_d_r;
  logic cs_s1_r, cs_s2_r, cs_d_r;
  always_ff @(posedge clock) begin
    if (reset) begin
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_d_r <= 1'b0;
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_d_r <= 1'b1;
    end else begin
      sck_s1_r <= link.sck;
      sck_s2_r <= sck_s1_r;
      sck_d_r <= sck_s2_r;
      cs_s1_r <= link.cs_n;
      cs_s2_r <= cs_s1_r;
      cs_d_r <= cs_s2_r;
    end
  end
  wire sck_fall = sck_d_r & ~sck_s2_r;
  // Select tied low never rises, so two-wire offers no abort
  wire cs_rise = ~cs_d_r & cs_s2_r;
  wire cs_low = ~cs_s2_r;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  asc_pkg::asc_state_t state_r, state_nxt;
  logic [31:0] conv_cnt_r;
  logic [15:0] shift_r;
  logic [4:0] fall_cnt_r;
  logic sdo_r;
  wire conv_done = (state_r == asc_pkg::ASC_CONVERT) && (conv_cnt_r == 32'(CONV_CYCLES - 1));
  // Idle-low at end of conversion skips sleep only when select is already low (two-wire)
  wire go_output = cs_low & ~sck_s2_r;
  // Sixteenth fall ends output; with idle-high the first fall only presents the
  // sign without shifting or counting, so count reaches sixteen at the seventeenth pulse
  wire last_fall = sck_fall && (fall_cnt_r == 5'h0f);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      asc_pkg::ASC_CONVERT: begin
        if (conv_done) begin
          state_nxt = go_output ? asc_pkg::ASC_OUTPUT : asc_pkg::ASC_SLEEP;
        end
      end
      asc_pkg::ASC_SLEEP: begin
        if (cs_low) begin
          state_nxt = asc_pkg::ASC_OUTPUT;
        end
      end
      default: begin
        if (cs_rise || last_fall) begin
          state_nxt = asc_pkg::ASC_CONVERT;
        end
      end
    endcase
  end

  // Idle-high reads see a leading fall that returns to high before data; that
  // first fall after entering output is the sign-bit presentation edge.
  logic hi_entry_r;
  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= asc_pkg::ASC_CONVERT;
      conv_cnt_r <= 32'h0;
      shift_r <= asc_pkg::SAMPLE_RESET;
      fall_cnt_r <= 5'h0;
      hi_entry_r <= 1'b0;
      last_result <= asc_pkg::SAMPLE_RESET;
    end else begin
      state_r <= state_nxt;
      conv_cnt_r <= (state_r == asc_pkg::ASC_CONVERT && !conv_done) ? conv_cnt_r + 32'h1 : 32'h0;
      if (conv_done) begin
        shift_r <= sample_code;
        last_result <= sample_code;
        fall_cnt_r <= 5'h0;
        hi_entry_r <= sck_s2_r;
      end else if (state_r == asc_pkg::ASC_OUTPUT && sck_fall) begin
        if (hi_entry_r) begin
          hi_entry_r <= 1'b0;
        end else begin
          shift_r <= {shift_r[14:0], 1'b0};
          fall_cnt_r <= fall_cnt_r + 5'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // Serial data output
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      sdo_r <= 1'b1;
    end else if (state_r == asc_pkg::ASC_CONVERT) begin
      sdo_r <= 1'b1;
    end else if (state_r == asc_pkg::ASC_SLEEP || hi_entry_r) begin
      sdo_r <= 1'b0;
    end else begin
      sdo_r <= shift_r[15];
    end
  end
  assign link.sdo = sdo_r;
  assign conv_busy = (state_r == asc_pkg::ASC_CONVERT);
endmodule
`default_nettype wire

// ===== rtl/asc_host.sv
`timescale 1ns/1ns
`default_nettype none
module asc_host (
  input wire logic clock,
  input wire logic reset,
  asc_link_if.host link,
  input wire logic cpol,
  input wire logic two_wire,
  input wire logic read_req,
  input wire logic [4:0] read_len,
  output logic read_busy,
  output logic read_done,
  output logic [15:0] read_data
);
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  typedef enum logic [1:0] {AH_IDLE, AH_LOW, AH_HIGH, AH_END} asc_host_state_t;
  asc_host_state_t state_r;
  logic [3:0] div_r;
  logic [4:0] cnt_r;
  logic [4:0] len_r;
  logic sck_r, cs_n_r;
  logic sdo_s1_r, sdo_s2_r;
  wire tick = (div_r == 4'(asc_pkg::SCK_HALF_CYCLES - 1));

  always_ff @(posedge clock) begin
    if (reset) begin
      sdo_s1_r <= 1'b1;
      sdo_s2_r <= 1'b1;
    end else begin
      sdo_s1_r <= link.sdo;
      sdo_s2_r <= sdo_s1_r;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= AH_IDLE;
      div_r <= 4'h0;
      cnt_r <= 5'h0;
      len_r <= 5'h0;
      sck_r <= 1'b0;
      cs_n_r <= 1'b1;
      read_done <= 1'b0;
      read_data <= 16'h0;
    end else begin
      read_done <= 1'b0;
      div_r <= (state_r == AH_IDLE || tick) ? 4'h0 : div_r + 4'h1;
      case (state_r)
        AH_IDLE: begin
          sck_r <= cpol;
          cs_n_r <= ~two_wire;
          if (read_req) begin
            cs_n_r <= 1'b0;
            cnt_r <= 5'h0;
            len_r <= read_len;
            state_r <= AH_LOW;
          end
        end
        // Data is taken on the rising edge of the first sixteen pulses only; a
        // seventeenth pulse merely restarts the converter and carries no bit
        AH_LOW: begin
          if (tick) begin
            sck_r <= ~cpol;
            if (!cpol && !cnt_r[4]) begin
              read_data <= {read_data[14:0], sdo_s2_r};
            end
            state_r <= AH_HIGH;
          end
        end
        AH_HIGH: begin
          if (tick) begin
            sck_r <= cpol;
            if (cpol && !cnt_r[4]) begin
              read_data <= {read_data[14:0], sdo_s2_r};
            end
            cnt_r <= cnt_r + 5'h1;
            state_r <= (cnt_r + 5'h1 >= len_r) ? AH_END : AH_LOW;
          end
        end
        default: begin
          if (tick) begin
            cs_n_r <= ~two_wire;
            read_done <= 1'b1;
            state_r <= AH_IDLE;
          end
        end
      endcase
    end
  end
  assign link.sck = sck_r;
  assign link.cs_n = cs_n_r;
  assign read_busy = (state_r != AH_IDLE);
endmodule
`default_nettype wire

// ===== testbench/asc_link_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module asc_link_monitor #(
  parameter int CONV_CYCLES = 300
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic sdo
);
  // ----------------
  // Helpers
  // ----------------
  logic sck_r;
  logic cs_r;
  logic [3:0] since_r;
  logic [31:0] hi_r;
  // A falling clock or any select change is a cause for sdo to move
  wire evt = (sck_r & ~sck) | (cs_r ^ cs_n);
  always_ff @(posedge clock) begin
    sck_r <= sck;
    cs_r <= cs_n;
    since_r <= (reset || evt) ? 4'h0 : since_r + {3'h0, since_r != 4'hf};
    hi_r <= (reset || !sdo) ? 32'h0 : hi_r + 32'h1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  // ----------------
  // Properties
  // ----------------
  sequence s_hi;
    sdo ##1 sdo [*8];
  endsequence
  property p_rst; $fell(reset) |-> sdo && cs_n; endproperty
  property p_half; $changed(sck) |=> $stable(sck) [*6]; endproperty
  property p_wait; $fell(cs_n) |=> $stable(sck) [*6]; endproperty
  property p_cs; $changed(cs_n) |-> $stable(sck); endproperty
  property p_rise; $rose(sdo) |-> since_r <= 4'h8; endproperty
  property p_abort; $rose(cs_n) |-> ##[1:8] s_hi; endproperty
  // Without a link cause, a falling sdo can only be the end of a full conversion
  property p_done; $fell(sdo) && since_r > 4'h8 |-> hi_r >= CONV_CYCLES - 4; endproperty
  property p_stand; $rose(sck) && !cs_n |=> $stable(sdo) [*5]; endproperty
  a_rst: assert property (p_rst) else $error("sdo or cs_n wrong after reset");
  a_half: assert property (p_half) else $error("sck half period too short");
  a_wait: assert property (p_wait) else $error("sck moved too soon after select");
  a_cs: assert property (p_cs) else $error("select moved with sck");
  a_rise: assert property (p_rise) else $error("sdo rose without cause");
  a_abort: assert property (p_abort) else $error("no conversion after select rise");
  a_done: assert property (p_done) else $error("conversion cut short");
  a_stand: assert property (p_stand) else $error("sdo moved after sampling edge");
endmodule
`default_nettype wire

// ===== testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if (!((g) === (e))) begin err_count++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module tb;
  typedef struct {logic cpol; logic two; logic [4:0] len; logic [15:0] code;} asc_row_t;
  // ----------------
  // Wiring
  // ----------------
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic cpol = 1'b0;
  logic two_wire = 1'b0;
  logic read_req = 1'b0;
  logic [4:0] read_len = 5'h10;
  logic [15:0] sample_code = 16'h0000;
  logic conv_busy;
  logic read_busy;
  logic read_done;
  logic [15:0] last_result;
  logic [15:0] read_data;
  int err_count = 0;
  int cmp_count = 0;
  int n;
  time t0;
  // Mode, clocks sent, code; length 1 aborts after the sign bit
  asc_row_t rows [7] = '{'{1'b0, 1'b0, 5'h10, 16'h8000}, '{1'b1, 1'b0, 5'h10, 16'hffff},
    '{1'b1, 1'b0, 5'h11, 16'h0000}, '{1'b0, 1'b0, 5'h01, 16'h4000},
    '{1'b1, 1'b1, 5'h11, 16'hc000}, '{1'b0, 1'b1, 5'h10, 16'h7fff},
    '{1'b0, 1'b0, 5'h10, 16'hbfff}};
  asc_link_if link ();
  asc_device #(.CONV_CYCLES(300)) asc_device_inst (.clock(clock), .reset(reset), .link(link),
    .sample_code(sample_code), .conv_busy(conv_busy), .last_result(last_result));
  asc_host asc_host_inst (.clock(clock), .reset(reset), .link(link), .cpol(cpol),
    .two_wire(two_wire), .read_req(read_req), .read_len(read_len), .read_busy(read_busy),
    .read_done(read_done), .read_data(read_data));
  asc_link_monitor #(.CONV_CYCLES(300)) asc_link_monitor_inst (.clock(clock), .reset(reset),
    .sck(link.sck), .cs_n(link.cs_n), .sdo(link.sdo));
  always #5 clock = ~clock;
  // ----------------
  // Tasks
  // ----------------
  task tally_and_finish;
    if (err_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task do_read(input logic [4:0] len);
    read_len <= len;
    read_req <= 1'b1;
    @(posedge clock);
    read_req <= 1'b0;
    @(posedge clock);
    `CHK("read_busy", 1'b1, read_busy)
    for (n = 0; read_done !== 1'b1 && n < 600; n++) @(posedge clock);
    `CHK("read_done", 1'b1, read_done)
    `CHK("read_busy_end", 1'b0, read_busy)
  endtask
  // Extra edges let sdo settle after the state change
  task wait_idle;
    for (n = 0; conv_busy !== 1'b0 && n < 600; n++) @(posedge clock);
    repeat (3) @(posedge clock);
  endtask
  initial begin
    #150000;
    err_count++;
    tally_and_finish();
  end
  // ----------------
  // Sequence
  // ----------------
  initial begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    // Modes change only while converting, so no select edge lands in output
    foreach (rows[i]) begin
      cpol <= rows[i].cpol;
      @(posedge clock);
      two_wire <= rows[i].two;
      sample_code <= rows[i].code;
      wait_idle();
      `CHK("last_result", rows[i].code, last_result)
      if (rows[i].two) `CHK("sdo_idle", rows[i].cpol ? 1'b0 : rows[i].code[15], link.sdo)
      do_read(rows[i].len);
      if (rows[i].len != 5'h01) `CHK("read_data", rows[i].code, read_data)
      repeat (6) @(posedge clock);
      `CHK("restart", 1'b1, conv_busy)
    end
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    sample_code <= 16'h1234;
    t0 = $time;
    repeat (2) @(posedge clock);
    `CHK("sdo_rst", 1'b1, link.sdo)
    do_read(5'h10);
    `CHK("ignored", 1'b1, conv_busy)
    wait_idle();
    `CHK("conv_len", 1'b1, ($time - t0) >= 2900 && ($time - t0) <= 3100)
    `CHK("result", 16'h1234, last_result)
    tally_and_finish();
  end
endmodule
`default_nettype wire
